// ### src/ofb_regs.svh
// register offsets, fuse map positions and timing figures of the fuse box controller
`ifndef OFB_REGS_SVH
`define OFB_REGS_SVH
`define OFB_OFF_CTRL 8'h00
`define OFB_OFF_MSEL 8'h04
`define OFB_OFF_DATA 8'h08
`define OFB_OFF_HIDE 8'h0C
`define OFB_OFF_STAT 8'h10
`define OFB_OFF_WORD0 8'h20
`define OFB_NWORDS 10
`define OFB_KEY_WORDS 9
`define OFB_B_WLOCK 312
`define OFB_B_BOOT 313
`define OFB_B_DBG 314
`define OFB_B_SBOOT 315
`define OFB_B_KEY 316
`define OFB_TRIM_LO 305
`define OFB_CTRL_GO 0
`define OFB_HIDE_BIT 0
`define OFB_ST_BUSY 0
`define OFB_ST_REFUSED 1
`define OFB_ST_SUPPLY 2
`define OFB_ST_HIDDEN 3
`define OFB_ST_TEST 4
`define OFB_BOOT_ROM 2'h0
`define OFB_PROG_NS 1000
`define OFB_CLK_MHZ 25
`endif

// ### src/ofb_pkg.sv
// types shared by the fuse box controller and its fuse array
package ofb_pkg;
   typedef enum logic {OFB_IDLE, OFB_BURN} ofb_fsm_t;
   typedef logic [31:0] ofb_word_t;
   typedef struct packed {
      ofb_word_t [9:0] words;
   } ofb_array_t;
   typedef struct packed {
      logic sup_m;
      logic sup_r;
      logic tst_m;
      logic tst_r;
      logic [1:0] bms_m;
      logic [1:0] bms_r;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic rd_pend;
      logic [7:0] rd_addr;
      logic hready;
      logic hresp;
      logic [31:0] hrdata;
      logic [3:0] sel;
      logic [31:0] data;
      logic hide;
      logic hide_used;
      logic refused;
      ofb_fsm_t fsm;
      logic [15:0] cnt;
      logic burn;
      logic boot_rom_only;
      logic dbg_off;
      logic sboot_off;
      logic key_lock;
      logic [6:0] trim;
      logic [1:0] boot_sel;
   } ofb_state_t;
endpackage : ofb_pkg

// ### src/ofb_fuse_array.sv
// one-time-programmable fuse storage, ten words of flip-flops that only gain ones
`timescale 1ns/1ps
`include "ofb_regs.svh"
module ofb_fuse_array #(
   parameter int NWORDS = `OFB_NWORDS
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // burn request
   input wire logic burn,
   input wire logic [3:0] burn_word,
   input wire logic [31:0] burn_data,
   // raw fuse state
   output logic [NWORDS*32-1:0] fuse_bits
);
   ofb_pkg::ofb_array_t st_q;
   ofb_pkg::ofb_array_t st_d;

   // a burn can only add ones; zeros in the data leave a word as it was
   always_comb
   begin
      st_d = st_q;
      for (int i = 0; i < NWORDS; i++)
      begin
         if (burn && burn_word == 4'(i))
         begin
            st_d.words[i] = st_q.words[i] | burn_data; // see RL14
         end
      end
   end

   // blank array after reset stands in for the real nonvolatile cells
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // flat view, bit 32*i+j is bit j of word i
   genvar g;
   generate
      for (g = 0; g < NWORDS; g++)
      begin : g_word
         assign fuse_bits[g*32 +: 32] = st_q.words[g]; // see RL1
      end
   endgenerate
endmodule : ofb_fuse_array

// ### src/ofb_ctrl.sv
// fuse box controller: AHB-Lite register slave, burn sequencer and fuse-driven controls
// What this block does
// RL1: holds 320 one-time bits; a programmed bit reads back as one.
// RL2: ten status words, zero to nine, show the fuse bit groups.
// RL3: a write-once hide mask blanks status words one to nine.
// RL4: with the fuse supply unpowered every fuse bit reads as one.
// RL5: one 32-bit data register feeds each burn of one word.
// RL6: a word-pick field selects which of words zero to nine is burned.
// RL7: bits 319-312 configuration, 311-305 oscillator trim, 304-288 reserved.
// RL8: bits 287-0 are keys; once bit 316 is set they are locked.
// RL9: once bit 312 is set every further burn is refused.
// RL10: in test mode with bit 312 set all fuse access is blocked.
// RL11: once bit 313 is set, boot pins are ignored and boot is from ROM.
// RL12: bit 314 set disables debug scan port and tap controller.
// RL13: bit 315 set disables the secure boot loader.
// RL14: a burn only turns zeros into ones; zero data bits change nothing.
// RL15: hidden words read zero until reset; later mask writes are ignored.
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "ofb_regs.svh"
module ofb_ctrl #(
   parameter int PROG_NS = `OFB_PROG_NS,
   parameter int CLK_MHZ = `OFB_CLK_MHZ
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // pins from outside the clock domain
   input wire logic fuse_supply,
   input wire logic test_mode,
   input wire logic [1:0] boot_choice_pins,
   // device-wide controls
   output logic boot_rom_only,
   output logic [1:0] boot_choice,
   output logic debug_port_off,
   output logic secure_boot_off,
   output logic key_lock,
   output logic [6:0] oscillator_trim
);
   // least burn time rounds up to whole cycles
   localparam int PROG_CYC_I = (PROG_NS * CLK_MHZ + 999) / 1000;
   localparam logic [15:0] PROG_CYC = 16'(PROG_CYC_I < 1 ? 1 : PROG_CYC_I);
   localparam int NBITS = `OFB_NWORDS * 32;

   ofb_pkg::ofb_state_t st_q;
   ofb_pkg::ofb_state_t st_d;
   logic [NBITS-1:0] fuse_raw;
   logic [NBITS-1:0] fuse_eff;
   logic wlock;
   logic blocked;
   logic busy;
   logic addr_take;
   logic go;
   logic go_ok;
   logic [7:0] widx;
   logic [3:0] ridx;
   logic [31:0] rword;

   // fuse storage
   ofb_fuse_array #(
      .NWORDS(`OFB_NWORDS)
   ) u_array (
      .hclk(hclk),
      .hresetn(hresetn),
      .burn(st_q.burn),
      .burn_word(st_q.sel),
      .burn_data(st_q.data),
      .fuse_bits(fuse_raw)
   );

   // a floating supply must fail safe: every security control active
   assign fuse_eff = st_q.sup_r ? fuse_raw : {NBITS{1'b1}}; // see RL4
   assign wlock = fuse_eff[`OFB_B_WLOCK];
   assign blocked = st_q.tst_r && wlock; // see RL10
   assign busy = (st_q.fsm == ofb_pkg::OFB_BURN) || st_q.burn;
   assign addr_take = hsel && htrans[1] && hready;
   assign go = st_q.wr_pend && st_q.wr_addr == `OFB_OFF_CTRL && hwdata[`OFB_CTRL_GO];
   // burn permission: lock, key lock, word range, busy
   assign go_ok = go && !busy && !wlock // see RL9
      && st_q.sel < 4'(`OFB_NWORDS) // see RL6
      && !(st_q.sel < 4'(`OFB_KEY_WORDS) && fuse_eff[`OFB_B_KEY]); // see RL8
   assign widx = 8'((st_q.rd_addr - `OFB_OFF_WORD0) >> 2);
   assign ridx = widx[3:0];

   // status word view for reads
   always_comb
   begin
      rword = fuse_eff[ridx*32 +: 32]; // see RL2
      if (blocked)
      begin
         rword = '0; // see RL10
      end
      else if (st_q.hide && ridx != 4'h0)
      begin
         rword = '0; // see RL3
      end
   end

   // next state
   always_comb
   begin
      st_d = st_q;
      // two flip-flops on every pin before use
      st_d.sup_m = fuse_supply;
      st_d.sup_r = st_q.sup_m;
      st_d.tst_m = test_mode;
      st_d.tst_r = st_q.tst_m;
      st_d.bms_m = boot_choice_pins;
      st_d.bms_r = st_q.bms_m;
      st_d.hresp = 1'b0;
      st_d.wr_pend = 1'b0;
      st_d.burn = 1'b0;
      // address phase; reads take one wait state so a write just before is seen
      if (st_q.rd_pend)
      begin
         st_d.rd_pend = 1'b0;
         st_d.hready = 1'b1;
         st_d.hrdata = '0;
         unique case (st_q.rd_addr)
            `OFB_OFF_MSEL: st_d.hrdata = {28'h0000000, st_q.sel};
            `OFB_OFF_DATA: st_d.hrdata = st_q.data;
            `OFB_OFF_HIDE: st_d.hrdata = {31'h00000000, st_q.hide};
            `OFB_OFF_STAT:
            begin
               st_d.hrdata[`OFB_ST_BUSY] = busy;
               st_d.hrdata[`OFB_ST_REFUSED] = st_q.refused;
               st_d.hrdata[`OFB_ST_SUPPLY] = st_q.sup_r;
               st_d.hrdata[`OFB_ST_HIDDEN] = st_q.hide;
               st_d.hrdata[`OFB_ST_TEST] = st_q.tst_r;
            end
            default:
            begin
               if (st_q.rd_addr >= `OFB_OFF_WORD0 && widx < 8'(`OFB_NWORDS)
                  && st_q.rd_addr[1:0] == 2'h0)
               begin
                  st_d.hrdata = rword;
               end
            end
         endcase
      end
      else if (addr_take)
      begin
         st_d.wr_pend = hwrite;
         st_d.wr_addr = haddr[7:0];
         st_d.rd_pend = !hwrite;
         st_d.rd_addr = haddr[7:0];
         st_d.hready = hwrite;
      end
      // data phase of a write
      if (st_q.wr_pend)
      begin
         unique case (st_q.wr_addr)
            `OFB_OFF_MSEL:
            begin
               if (!busy)
               begin
                  st_d.sel = hwdata[3:0]; // see RL6
               end
            end
            `OFB_OFF_DATA:
            begin
               if (!busy)
               begin
                  st_d.data = hwdata; // see RL5
               end
            end
            `OFB_OFF_HIDE:
            begin
               if (!st_q.hide_used)
               begin
                  st_d.hide = hwdata[`OFB_HIDE_BIT]; // see RL15
                  st_d.hide_used = 1'b1;
               end
            end
            `OFB_OFF_STAT:
            begin
               if (hwdata[`OFB_ST_REFUSED])
               begin
                  st_d.refused = 1'b0;
               end
            end
            default:
            begin
            end
         endcase
      end
      // refusal set wins over a clear in the same cycle
      if (go && !go_ok)
      begin
         st_d.refused = 1'b1;
      end
      // burn sequencer
      unique case (st_q.fsm)
         ofb_pkg::OFB_IDLE:
         begin
            if (go_ok)
            begin
               st_d.fsm = ofb_pkg::OFB_BURN;
               st_d.cnt = PROG_CYC - 16'h0001;
            end
         end
         ofb_pkg::OFB_BURN:
         begin
            if (st_q.cnt == 16'h0000)
            begin
               st_d.burn = 1'b1; // see RL5
               st_d.fsm = ofb_pkg::OFB_IDLE;
            end
            else
            begin
               st_d.cnt = st_q.cnt - 16'h0001;
            end
         end
      endcase
      // device controls follow the effective fuses
      st_d.boot_rom_only = fuse_eff[`OFB_B_BOOT]; // see RL11
      st_d.boot_sel = fuse_eff[`OFB_B_BOOT] ? `OFB_BOOT_ROM : st_q.bms_r; // see RL11
      st_d.dbg_off = fuse_eff[`OFB_B_DBG]; // see RL12
      st_d.sboot_off = fuse_eff[`OFB_B_SBOOT]; // see RL13
      st_d.key_lock = fuse_eff[`OFB_B_KEY]; // see RL8
      st_d.trim = fuse_eff[`OFB_TRIM_LO +: 7]; // see RL7
   end

   // state register; controls reset to their safe, active side
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_q <= '0;
         st_q.hready <= 1'b1;
         st_q.fsm <= ofb_pkg::OFB_IDLE;
         st_q.boot_rom_only <= 1'b1;
         st_q.dbg_off <= 1'b1;
         st_q.sboot_off <= 1'b1;
         st_q.key_lock <= 1'b1;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // outputs, all from flip-flops
   assign hreadyout = st_q.hready;
   assign hresp = st_q.hresp;
   assign hrdata = st_q.hrdata;
   assign boot_rom_only = st_q.boot_rom_only;
   assign boot_choice = st_q.boot_sel;
   assign debug_port_off = st_q.dbg_off;
   assign secure_boot_off = st_q.sboot_off;
   assign key_lock = st_q.key_lock;
   assign oscillator_trim = st_q.trim;

   // checks
   unpowered_ones_a: assert property ( // see RL4
      @(posedge hclk) disable iff (!hresetn)
      !st_q.sup_r |=> key_lock && debug_port_off && boot_rom_only && secure_boot_off)
      else $error("unpowered fuses did not force controls");

   wlock_refuse_a: assert property ( // see RL9
      @(posedge hclk) disable iff (!hresetn)
      go && wlock |=> st_q.fsm == ofb_pkg::OFB_IDLE ##1 !st_q.burn)
      else $error("burn started with write lock set");

   key_refuse_a: assert property ( // see RL8
      @(posedge hclk) disable iff (!hresetn)
      go && fuse_eff[`OFB_B_KEY] && st_q.sel < 4'(`OFB_KEY_WORDS) |=> st_q.refused)
      else $error("key word burn not refused");

   burn_or_a: assert property ( // see RL14
      @(posedge hclk) disable iff (!hresetn)
      st_q.burn |=> fuse_raw[$past(st_q.sel)*32 +: 32]
         == ($past(fuse_raw[st_q.sel*32 +: 32]) | $past(st_q.data)))
      else $error("burn did not or data into word");

   hide_once_a: assert property ( // see RL15
      @(posedge hclk) disable iff (!hresetn)
      st_q.hide_used |=> st_q.hide_used && $stable(st_q.hide))
      else $error("hide mask changed after first write");

   hidden_zero_a: assert property ( // see RL3
      @(posedge hclk) disable iff (!hresetn)
      st_q.rd_pend && st_q.hide && st_q.rd_addr > `OFB_OFF_WORD0 |=> hrdata == 32'h00000000)
      else $error("hidden word read nonzero");

   test_block_a: assert property ( // see RL10
      @(posedge hclk) disable iff (!hresetn)
      st_q.rd_pend && blocked && st_q.rd_addr >= `OFB_OFF_WORD0 |=> hrdata == 32'h00000000)
      else $error("fuse word readable in locked test mode");

   rom_boot_a: assert property ( // see RL11
      @(posedge hclk) disable iff (!hresetn)
      fuse_eff[`OFB_B_BOOT] |=> boot_choice == `OFB_BOOT_ROM && boot_rom_only)
      else $error("boot pins not ignored");

   burn_span_a: assert property ( // see RL5
      @(posedge hclk) disable iff (!hresetn)
      go_ok |=> !st_q.burn ##[1:1000] st_q.burn)
      else $error("burn did not follow start in time");

   read_wait_a: assert property ( // see RL2
      @(posedge hclk) disable iff (!hresetn)
      addr_take && !hwrite && !st_q.rd_pend |=> !hreadyout ##1 hreadyout)
      else $error("read did not take one wait state");

   lock_refused_a: assert property ( // see RL9
      @(posedge hclk) disable iff (!hresetn)
      go && wlock |=> st_q.refused)
      else $error("burn request not refused under write lock");

   sel_range_a: assert property ( // see RL6
      @(posedge hclk) disable iff (!hresetn)
      go && st_q.sel >= 4'(`OFB_NWORDS) |=> st_q.refused)
      else $error("burn of a word past nine not refused");

   fuse_keep_a: assert property ( // see RL1
      @(posedge hclk) disable iff (!hresetn)
      ($past(fuse_raw) & ~fuse_raw) == {NBITS{1'b0}})
      else $error("programmed fuse bit went back to zero");

   trim_follow_a: assert property ( // see RL7
      @(posedge hclk) disable iff (!hresetn)
      1'b1 |=> oscillator_trim == $past(fuse_eff[`OFB_TRIM_LO +: 7]))
      else $error("oscillator trim does not follow its fuses");

   debug_off_a: assert property ( // see RL12
      @(posedge hclk) disable iff (!hresetn)
      fuse_eff[`OFB_B_DBG] |=> debug_port_off)
      else $error("debug port left on with its fuse set");

   sboot_off_a: assert property ( // see RL13
      @(posedge hclk) disable iff (!hresetn)
      fuse_eff[`OFB_B_SBOOT] |=> secure_boot_off)
      else $error("secure boot loader left on with its fuse set");
endmodule : ofb_ctrl

// ### tb/ofb_ctrl_bench.sv
// self-checking bench for the fuse box controller over its bus and control pins
`timescale 1ns/1ps
`include "ofb_regs.svh"
module ofb_ctrl_bench;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic fuse_supply = 1'b1;
   logic test_mode = 1'b0;
   logic [1:0] pins = 2'h0;
   wire hreadyout;
   wire hresp;
   wire [31:0] hrdata;
   wire [12:0] ctls;
   int fails = 0;
   int compares = 0;
   int seed = 32'h4D3EC4D4;
   bit nchk[$];
   logic [31:0] nexp[$];
   logic [12:0] ctl_q[$];
   logic rd_pend = 1'b0;
   bit c;
   logic [31:0] e, dmy, w0, w9, d;
   logic tm = 1'b0;
   logic hid = 1'b0;

   ofb_ctrl dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fuse_supply(fuse_supply),
      .test_mode(test_mode), .boot_choice_pins(pins), .boot_rom_only(ctls[12]),
      .boot_choice(ctls[11:10]), .debug_port_off(ctls[9]), .secure_boot_off(ctls[8]),
      .key_lock(ctls[7]), .oscillator_trim(ctls[6:0])
   );

   // 25 MHz bus clock
   always #20 hclk = ~hclk;

   task stop_test;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : stop_test

   task cmp_rd(input logic [31:0] g, input logic [31:0] x);
      compares++;
      if (g !== x)
      begin
         fails++;
         $display("Error at %0t: read %h expected %h", $time, g, x);
      end
   endtask : cmp_rd

   task cmp_ctl(input logic [12:0] g, input logic [12:0] x);
      compares++;
      if (g !== x)
      begin
         fails++;
         $display("Error at %0t: controls %h expected %h", $time, g, x);
      end
   endtask : cmp_ctl

   // read data is judged at the first ready edge after the address phase
   always @(posedge hclk)
   begin
      if (rd_pend && hreadyout === 1'b1)
      begin
         c = nchk.pop_front();
         e = nexp.pop_front();
         if (c)
            cmp_rd(hrdata, e);
         cmp_rd({31'h00000000, hresp}, 32'h00000000);
      end
      if (hreadyout === 1'b1)
         rd_pend = hsel && htrans[1] && !hwrite;
   end

   // controls are levels, so the middle of the cycle is a safe look
   always @(negedge hclk)
      if (ctl_q.size() > 0)
         cmp_ctl(ctls, ctl_q.pop_front());

   // bounded wait for ready; a hang ends the run as a failure
   task wait_rdy;
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
      begin
         n++;
         if (n > 50)
         begin
            fails++;
            stop_test;
         end
         @(posedge hclk);
      end
   endtask : wait_rdy

   task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, input bit k,
      input logic [31:0] x, output logic [31:0] rd);
      if (!w)
      begin
         nchk.push_back(k);
         nexp.push_back(x);
      end
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy;
      rd = hrdata;
   endtask : ahb

   task wr(input logic [7:0] a, input logic [31:0] wd);
      ahb(1'b1, a, wd, 1'b0, 32'h0, dmy);
   endtask : wr

   task rd_chk(input logic [7:0] a, input logic [31:0] x);
      ahb(1'b0, a, 32'h0, 1'b1, x, dmy);
   endtask : rd_chk

   function logic [7:0] wa(input int i);
      return 8'(`OFB_OFF_WORD0 + 4 * i);
   endfunction : wa

   // status as the bench expects it, refused flag given by the caller
   task stat_chk(input logic r);
      rd_chk(`OFB_OFF_STAT, {27'h0, tm, hid, fuse_supply, r, 1'b0});
   endtask : stat_chk

   // controls expected from the configuration word after a short settle
   task ctl_chk(input logic [31:0] v);
      repeat (2) @(posedge hclk);
      ctl_q.push_back({v[25], v[25] ? 2'h0 : pins, v[26], v[27], v[28], v[23:17]});
      @(posedge hclk);
   endtask : ctl_chk

   task burn(input logic [3:0] s, input logic [31:0] v);
      int n;
      logic [31:0] st;
      wr(`OFB_OFF_MSEL, {28'h0, s});
      wr(`OFB_OFF_DATA, v);
      wr(`OFB_OFF_CTRL, 32'h1);
      n = 0;
      st = 32'h1;
      while (st[0] !== 1'b0)
      begin
         n++;
         if (n > 100)
         begin
            fails++;
            stop_test;
         end
         ahb(1'b0, `OFB_OFF_STAT, 32'h0, 1'b0, 32'h0, st);
      end
   endtask : burn

   // main sequence
   initial
   begin
      pins = 2'($random(seed));
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (6) @(posedge hclk);
      for (int i = 0; i < 10; i++)
         rd_chk(wa(i), 32'h0);
      stat_chk(1'b0);
      ctl_chk(32'h0);
      $display("blank array test done");
      w0 = $random(seed);
      burn(4'h0, w0);
      rd_chk(wa(0), w0);
      rd_chk(`OFB_OFF_MSEL, 32'h00000000);
      rd_chk(`OFB_OFF_DATA, w0);
      d = $random(seed);
      burn(4'h0, d);
      w0 = w0 | d;
      rd_chk(wa(0), w0);
      w9 = 32'h0E000000 | (32'($random(seed)) & 32'h00FE0000);
      burn(4'h9, w9);
      rd_chk(wa(9), w9);
      ctl_chk(w9);
      burn(4'hA, 32'h00000001);
      stat_chk(1'b1);
      wr(`OFB_OFF_STAT, 32'h2);
      $display("burn and config test done");
      fuse_supply <= 1'b0;
      repeat (6) @(posedge hclk);
      rd_chk(wa(0), 32'hFFFFFFFF);
      ctl_chk(32'hFFFFFFFF);
      fuse_supply <= 1'b1;
      repeat (6) @(posedge hclk);
      ctl_chk(w9);
      $display("supply test done");
      burn(4'h9, 32'h10000000);
      w9 = w9 | 32'h10000000;
      ctl_chk(w9);
      burn(4'h3, 32'hA5A5A5A5);
      stat_chk(1'b1);
      rd_chk(wa(3), 32'h0);
      wr(`OFB_OFF_STAT, 32'h2);
      stat_chk(1'b0);
      test_mode <= 1'b1;
      tm = 1'b1;
      repeat (6) @(posedge hclk);
      rd_chk(wa(0), w0);
      $display("key lock test done");
      burn(4'h9, 32'h01000000);
      w9 = w9 | 32'h01000000;
      rd_chk(wa(0), 32'h0);
      rd_chk(wa(9), 32'h0);
      test_mode <= 1'b0;
      tm = 1'b0;
      repeat (6) @(posedge hclk);
      burn(4'h9, 32'h20000000);
      stat_chk(1'b1);
      rd_chk(wa(9), w9);
      ctl_chk(w9);
      wr(`OFB_OFF_STAT, 32'h2);
      $display("write lock test done");
      wr(`OFB_OFF_HIDE, 32'h1);
      hid = 1'b1;
      rd_chk(wa(0), w0);
      rd_chk(wa(9), 32'h0);
      wr(`OFB_OFF_HIDE, 32'h0);
      rd_chk(wa(9), 32'h0);
      rd_chk(`OFB_OFF_HIDE, 32'h00000001);
      stat_chk(1'b0);
      $display("hide mask test done");
      stop_test;
   end
endmodule : ofb_ctrl_bench
